// *** design/rtc_link_pkg.sv ***
// Shared constants and state types for the clock chip two-wire link
`default_nettype none
package rtc_link_pkg;

   // ****************************************
   // Bus identity and location map
   // ****************************************
   // Address byte is {DEV_ADDR, direction}, so D0h writes, D1h reads
   localparam logic [6:0] DEV_ADDR       = 7'h68;
   localparam int         PTR_W          = 6;     // 64 locations
   // Order: sub-second, sec, min, century/hours, day, date, month, year,
   // control 08h, watchdog 09h, alarms 0Ah-0Fh, reserved 10h-12h,
   // square wave 13h (position 20), user RAM 14h-3Fh
   localparam logic [5:0] LAST_CLOCK_LOC = 6'h07;
   localparam logic [7:0] MEM_RST        = 8'h00;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS  = 5;
   // Just under 400 kHz: a square 2500 ns clock would leave the low
   // half short of the 1.3 us minimum, so the period is stretched
   localparam int SCL_PERIOD_NS  = 2600;
   localparam int SCL_QTR_CYC    = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   localparam int RECOVERY_PROTECT_TIME_US       = 2000;   // recovery_protect_time
   localparam int REC_CYC        = RECOVERY_PROTECT_TIME_US * 1000 / CLK_PERIOD_NS;

   // ****************************************
   // State encodings
   // ****************************************
   typedef enum logic [3:0] {
      D_IDLE  = 4'h0,
      D_ADDR  = 4'h1,
      D_A_ACK = 4'h3,
      D_WORD  = 4'h2,
      D_W_ACK = 4'h6,
      D_WDATA = 4'h7,
      D_D_ACK = 4'h5,
      D_TX    = 4'h4,
      D_T_ACK = 4'hC,
      D_WAIT  = 4'hD
   } dev_state_t;

   typedef enum logic [2:0] {
      M_IDLE  = 3'h0,
      M_START = 3'h1,
      M_TX    = 3'h3,
      M_RX    = 3'h2,
      M_STOP  = 3'h6
   } mst_state_t;

endpackage
`default_nettype wire

// *** design/rtc_link_if.sv ***
// Two-wire link between the bus master and the clock chip front end
`timescale 1ns/1ps
`default_nettype none
interface rtc_link_if;
   logic scl;         // Bus clock, made by the master
   logic dev_sda_o;   // Device data drive value
   logic dev_sda_oe;  // Device drives data line
   logic mst_sda_o;   // Master data drive value
   logic mst_sda_oe;  // Master drives data line
   logic sda;         // Resolved data line level

   // Open drain with pull-up: any enabled low driver wins
   assign sda = ~((dev_sda_oe & ~dev_sda_o) | (mst_sda_oe & ~mst_sda_o));

   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport mst (output scl, input sda, output mst_sda_o, output mst_sda_oe);
endinterface
`default_nettype wire

// *** design/rtc_serial_slave_dev.sv ***
// Serial slave front end of the clock chip: link logic and supervisor side
//
// Function
// - Respond only to own address after start
// - Pointer spans 64 locations, sequential access
// - Fixed location order, clock bytes first
// - Supply fail aborts access, clears pointer
// - No writes until recovery time elapses
// - Master starts only on idle bus
// - Data edges with clock high: start, stop
// - Data stable while clock high
// - Bytes plus ninth acknowledge bit, unlimited count
// - Acknowledger holds data low during clock high
// - Device acknowledges every received byte
// - Master withholds last acknowledge; device releases
// - Random read: pointer write, repeated start, read
// - Pointer advances only on acknowledge clock
// - Reading continues through successive pointers until stop
// - Clock locations addressed halt user updates
// - Halt ends on stop or leaving clocks
// - Plain read starts at held pointer
// - Write stores byte, pointer advances, acknowledges
`timescale 1ns/1ps
`default_nettype none
module rtc_serial_slave_dev #(
   parameter int REC_CYCLES = rtc_link_pkg::REC_CYC
) (
   // Clocks, reset and enable
   input  wire logic  ref_clk,
   input  wire logic  reset,
   input  wire logic  clk_en,
   input  wire logic  link_clk,
   // Two-wire link
   rtc_link_if.dev    link,
   // Supervisor and clock core
   input  wire logic  supply_fail,
   output logic       update_halt,
   output logic       write_protect
);
   import rtc_link_pkg::*;

   // ****************************************
   // Supervisor side, ref_clk domain
   // ****************************************
   typedef struct packed {
      logic [1:0]  fail_s;   // Supply fail synchroniser
      logic [1:0]  halt_s;   // Halt level from link side
      logic        blk;      // Access blocked, supply below threshold
      logic        wprot;    // Writes ignored
      logic        halt;
      logic [18:0] rec_cnt;
   } ref_st_t;

   localparam ref_st_t REF_RST = '{fail_s: 2'h0, halt_s: 2'h0, blk: 1'b0,
                                   wprot: 1'b0, halt: 1'b0,
                                   rec_cnt: 19'h00000};

   ref_st_t r_ff;
   ref_st_t nxt_r;
   logic    lnk_halt;   // Halt level from the link side

   // Recovery counter restarts on every fail so a bouncing supply
   // cannot sneak a write in early
   always_comb begin
      nxt_r = r_ff;
      nxt_r.fail_s = {r_ff.fail_s[0], supply_fail};
      nxt_r.halt_s = {r_ff.halt_s[0], lnk_halt};
      nxt_r.halt   = r_ff.halt_s[1];
      nxt_r.blk    = r_ff.fail_s[1];
      if (r_ff.fail_s[1]) begin
         nxt_r.wprot   = 1'b1;
         nxt_r.rec_cnt = 19'h00000;
      end else if (r_ff.wprot) begin
         if (r_ff.rec_cnt == 19'(REC_CYCLES - 1)) begin
            nxt_r.wprot = 1'b0;
         end else begin
            nxt_r.rec_cnt = r_ff.rec_cnt + 19'h00001;
         end
      end
   end

   // Register the supervisor state
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         r_ff <= REF_RST;
      end else if (clk_en) begin
         r_ff <= nxt_r;
      end
   end

   assign update_halt   = r_ff.halt;
   assign write_protect = r_ff.wprot;

   // ****************************************
   // Link side, link_clk domain
   // ****************************************
   typedef struct packed {
      logic [1:0]            rst_s;
      logic [1:0]            en_s;
      logic [1:0]            blk_s;
      logic [1:0]            wp_s;
      logic [1:0]            scl_s;
      logic [1:0]            sda_s;
      logic                  scl_p;
      logic                  sda_p;
      dev_state_t            st;
      logic [2:0]            cnt;
      logic [7:0]            sh;
      logic                  rw;
      logic                  ackon;  // Inside the acknowledge bit
      logic                  mack;   // Master acknowledged our byte
      logic [PTR_W-1:0]      ptr;
      logic                  oe;
      logic                  halt;
      logic [63:0][7:0]      mem;
   } lnk_st_t;

   lnk_st_t l_ff;
   lnk_st_t nxt_l;
   assign lnk_halt = l_ff.halt;

   logic       scl;
   logic       sda;
   logic       start;
   logic       stop;
   logic       rise;
   logic       fall;
   logic [7:0] rx_byte;

   // Edges are judged on the second stage against the previous one,
   // so the first synchroniser stage feeds nothing but the second
   always_comb begin
      scl     = l_ff.scl_s[1];
      sda     = l_ff.sda_s[1];
      start   = scl & l_ff.scl_p & l_ff.sda_p & ~sda;
      stop    = scl & l_ff.scl_p & ~l_ff.sda_p & sda;
      rise    = scl & ~l_ff.scl_p;
      fall    = ~scl & l_ff.scl_p;
      rx_byte = {l_ff.sh[6:0], sda};
   end

   // Protocol engine: data is driven on falling clock edges only
   always_comb begin
      nxt_l = l_ff;
      nxt_l.rst_s = {l_ff.rst_s[0], reset};
      nxt_l.en_s  = {l_ff.en_s[0], clk_en};
      nxt_l.blk_s = {l_ff.blk_s[0], r_ff.blk};
      nxt_l.wp_s  = {l_ff.wp_s[0], r_ff.wprot};
      nxt_l.scl_s = {l_ff.scl_s[0], link.scl};
      nxt_l.sda_s = {l_ff.sda_s[0], link.sda};
      if (l_ff.rst_s[1]) begin
         nxt_l.scl_p = 1'b1;
         nxt_l.sda_p = 1'b1;
         nxt_l.st    = D_IDLE;
         nxt_l.cnt   = 3'h0;
         nxt_l.sh    = 8'h00;
         nxt_l.rw    = 1'b0;
         nxt_l.ackon = 1'b0;
         nxt_l.mack  = 1'b0;
         nxt_l.ptr   = 6'h00;
         nxt_l.oe    = 1'b0;
         nxt_l.mem   = {64{MEM_RST}};
      end else if (l_ff.en_s[1]) begin
         nxt_l.scl_p = scl;
         nxt_l.sda_p = sda;
         if (l_ff.blk_s[1]) begin
            // Bus inputs ignored while the supply is out of tolerance
            nxt_l.st    = D_IDLE;
            nxt_l.ptr   = 6'h00;
            nxt_l.oe    = 1'b0;
            nxt_l.ackon = 1'b0;
         end else if (start) begin
            nxt_l.st    = D_ADDR;
            nxt_l.cnt   = 3'h0;
            nxt_l.oe    = 1'b0;
            nxt_l.ackon = 1'b0;
         end else if (stop) begin
            nxt_l.st = D_IDLE;
            nxt_l.oe = 1'b0;
         end else begin
            case (l_ff.st)
               D_ADDR, D_WORD, D_WDATA: begin
                  if (rise) begin
                     nxt_l.sh  = rx_byte;
                     nxt_l.cnt = l_ff.cnt + 3'h1;
                     if (l_ff.cnt == 3'h7) begin
                        case (l_ff.st)
                           D_ADDR: begin
                              if (rx_byte[7:1] == DEV_ADDR) begin
                                 nxt_l.rw = rx_byte[0];
                                 nxt_l.st = D_A_ACK;
                              end else begin
                                 nxt_l.st = D_IDLE;
                              end
                           end
                           D_WORD: begin
                              nxt_l.ptr = rx_byte[5:0];
                              nxt_l.st  = D_W_ACK;
                           end
                           default: begin
                              if (!l_ff.wp_s[1]) begin
                                 nxt_l.mem[l_ff.ptr] = rx_byte;
                              end
                              nxt_l.st = D_D_ACK;
                           end
                        endcase
                     end
                  end
               end
               D_A_ACK, D_W_ACK, D_D_ACK: begin
                  if (rise && l_ff.ackon && l_ff.st == D_D_ACK) begin
                     nxt_l.ptr = l_ff.ptr + 6'h01;
                  end
                  if (fall && !l_ff.ackon) begin
                     nxt_l.oe    = 1'b1;
                     nxt_l.ackon = 1'b1;
                  end else if (fall) begin
                     nxt_l.ackon = 1'b0;
                     nxt_l.oe    = 1'b0;
                     nxt_l.cnt   = 3'h0;
                     if (l_ff.st == D_A_ACK && l_ff.rw) begin
                        // Read begins at whatever the pointer holds
                        nxt_l.st = D_TX;
                        nxt_l.sh = l_ff.mem[l_ff.ptr];
                        nxt_l.oe = ~l_ff.mem[l_ff.ptr][7];
                     end else if (l_ff.st == D_A_ACK) begin
                        nxt_l.st = D_WORD;
                     end else begin
                        nxt_l.st = D_WDATA;
                     end
                  end
               end
               D_TX: begin
                  if (rise) begin
                     nxt_l.cnt = l_ff.cnt + 3'h1;
                     if (l_ff.cnt == 3'h7) begin
                        nxt_l.st = D_T_ACK;
                     end
                  end else if (fall) begin
                     nxt_l.sh = {l_ff.sh[6:0], 1'b0};
                     nxt_l.oe = ~l_ff.sh[6];
                  end
               end
               D_T_ACK: begin
                  if (fall && !l_ff.ackon) begin
                     nxt_l.oe    = 1'b0;
                     nxt_l.ackon = 1'b1;
                  end else if (rise && l_ff.ackon) begin
                     nxt_l.mack = ~sda;
                     if (!sda) begin
                        nxt_l.ptr = l_ff.ptr + 6'h01;
                     end
                  end else if (fall) begin
                     nxt_l.ackon = 1'b0;
                     nxt_l.cnt   = 3'h0;
                     if (l_ff.mack) begin
                        nxt_l.st = D_TX;
                        nxt_l.sh = l_ff.mem[l_ff.ptr];
                        nxt_l.oe = ~l_ff.mem[l_ff.ptr][7];
                     end else begin
                        nxt_l.st = D_WAIT;
                        nxt_l.oe = 1'b0;
                     end
                  end
               end
               default: begin
                  nxt_l.oe = 1'b0;
               end
            endcase
         end
      end
      // Halt follows the pointer, so it drops when the pointer walks
      // past the clock bytes or the access ends with a stop
      nxt_l.halt = (nxt_l.st != D_IDLE) &&
                   (nxt_l.ptr <= LAST_CLOCK_LOC);
   end

   // Register the link state
   always_ff @(posedge link_clk) begin
      l_ff <= nxt_l;
   end

   assign link.dev_sda_o  = 1'b0;
   assign link.dev_sda_oe = l_ff.oe;

endmodule
`default_nettype wire

// *** design/rtc_bus_master.sv ***
// Two-wire bus master that reads and writes the clock chip
`timescale 1ns/1ps
`default_nettype none
module rtc_bus_master (
   // Clock, reset and enable
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   // Two-wire link
   rtc_link_if.mst          link,
   // Command port
   input  wire logic        cmd_valid,
   input  wire logic        cmd_read,
   input  wire logic        cmd_set_ptr,
   input  wire logic [5:0]  cmd_word_addr,
   input  wire logic [5:0]  cmd_len,
   output logic             cmd_ready,
   // Data port
   input  wire logic [7:0]  wr_data,
   output logic             wr_take,
   output logic [7:0]       rd_data,
   output logic             rd_valid,
   output logic             done,
   output logic             nack_err
);
   import rtc_link_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [1:0] sda_s;
      mst_state_t st;
      logic [7:0] qdiv;
      logic [1:0] q;      // Quarter of the bit period
      logic [3:0] bitn;   // 8 is the acknowledge bit
      logic [7:0] sh;
      logic [5:0] wadr;   // Word address kept for the second byte
      logic [1:0] stage;  // 0 addr W, 1 word, 2 addr R, 3 data
      logic       rd;
      logic [5:0] left;
      logic       scl;
      logic       oe;
      logic       ready;
      logic       take;
      logic       rdv;
      logic [7:0] rdd;
      logic       done;
      logic       err;
   } mst_st_t;

   localparam mst_st_t M_RST = '{sda_s: 2'h3, st: M_IDLE, qdiv: 8'h00,
      q: 2'h0, bitn: 4'h0, sh: 8'h00, wadr: 6'h00, stage: 2'h0, rd: 1'b0,
      left: 6'h00,
      scl: 1'b1, oe: 1'b0, ready: 1'b0, take: 1'b0, rdv: 1'b0,
      rdd: 8'h00, done: 1'b0, err: 1'b0};

   mst_st_t m_ff;
   mst_st_t nxt_m;

   logic sda;
   logic tick;

   // Bus clock comes from a quarter-period divider; all line changes
   // happen on quarter ticks, data only while the clock is low except at start and stop
   always_comb begin
      nxt_m = m_ff;
      sda   = m_ff.sda_s[1];
      tick  = (m_ff.qdiv == 8'(SCL_QTR_CYC - 1));
      nxt_m.sda_s = {m_ff.sda_s[0], link.sda};
      nxt_m.take  = 1'b0;
      nxt_m.rdv   = 1'b0;
      nxt_m.done  = 1'b0;
      nxt_m.qdiv  = tick ? 8'h00 : m_ff.qdiv + 8'h01;
      if (tick && m_ff.st != M_IDLE) begin
         nxt_m.q = m_ff.q + 2'h1;
      end
      case (m_ff.st)
         M_IDLE: begin
            nxt_m.scl   = 1'b1;
            nxt_m.oe    = 1'b0;
            nxt_m.ready = 1'b1;
            // Only begin on a quiet bus, both lines high
            if (cmd_valid && m_ff.ready && sda && m_ff.scl) begin
               nxt_m.ready = 1'b0;
               nxt_m.err   = 1'b0;
               nxt_m.rd    = cmd_read;
               nxt_m.left  = cmd_len;
               nxt_m.wadr  = cmd_word_addr;
               nxt_m.stage = (cmd_read && !cmd_set_ptr) ? 2'h2 : 2'h0;
               nxt_m.st    = M_START;
               nxt_m.q     = 2'h0;
               nxt_m.qdiv  = 8'h00;
            end
         end
         M_START: begin
            if (tick) begin
               case (m_ff.q)
                  2'h0: nxt_m.oe  = 1'b0;
                  2'h1: nxt_m.scl = 1'b1;
                  2'h2: nxt_m.oe  = 1'b1;
                  default: begin
                     nxt_m.scl  = 1'b0;
                     nxt_m.bitn = 4'h0;
                     nxt_m.sh   = {DEV_ADDR, m_ff.stage == 2'h2};
                     nxt_m.st   = M_TX;
                  end
               endcase
            end
         end
         M_TX: begin
            if (tick) begin
               case (m_ff.q)
                  2'h0: nxt_m.oe  = (m_ff.bitn != 4'h8) & ~m_ff.sh[7];
                  2'h1: nxt_m.scl = 1'b1;
                  2'h2: nxt_m.scl = 1'b1;
                  default: begin
                     nxt_m.scl = 1'b0;
                     if (m_ff.bitn != 4'h8) begin
                        nxt_m.sh   = {m_ff.sh[6:0], 1'b0};
                        nxt_m.bitn = m_ff.bitn + 4'h1;
                     end else if (sda) begin
                        nxt_m.err = 1'b1;
                        nxt_m.st  = M_STOP;
                     end else begin
                        nxt_m.bitn = 4'h0;
                        case (m_ff.stage)
                           2'h0: begin
                              nxt_m.stage = 2'h1;
                              nxt_m.sh    = {2'h0, m_ff.wadr};
                           end
                           2'h1: begin
                              if (m_ff.rd) begin
                                 nxt_m.stage = 2'h2;
                                 nxt_m.st    = M_START;
                              end else begin
                                 nxt_m.stage = 2'h3;
                                 nxt_m.sh    = wr_data;
                                 nxt_m.take  = 1'b1;
                              end
                           end
                           2'h2: begin
                              nxt_m.stage = 2'h3;
                              nxt_m.st    = M_RX;
                           end
                           default: begin
                              nxt_m.left = m_ff.left - 6'h01;
                              if (m_ff.left == 6'h01) begin
                                 nxt_m.st = M_STOP;
                              end else begin
                                 nxt_m.sh   = wr_data;
                                 nxt_m.take = 1'b1;
                              end
                           end
                        endcase
                     end
                  end
               endcase
            end
         end
         M_RX: begin
            if (tick) begin
               case (m_ff.q)
                  // Acknowledge all but the final byte
                  2'h0: nxt_m.oe  = (m_ff.bitn == 4'h8) &&
                                    (m_ff.left != 6'h01);
                  2'h1: nxt_m.scl = 1'b1;
                  2'h2: nxt_m.scl = 1'b1;
                  default: begin
                     nxt_m.scl = 1'b0;
                     if (m_ff.bitn != 4'h8) begin
                        nxt_m.sh   = {m_ff.sh[6:0], sda};
                        nxt_m.bitn = m_ff.bitn + 4'h1;
                        if (m_ff.bitn == 4'h7) begin
                           nxt_m.rdd = {m_ff.sh[6:0], sda};
                           nxt_m.rdv = 1'b1;
                        end
                     end else begin
                        nxt_m.bitn = 4'h0;
                        nxt_m.left = m_ff.left - 6'h01;
                        if (m_ff.left == 6'h01) begin
                           nxt_m.st = M_STOP;
                        end
                     end
                  end
               endcase
            end
         end
         M_STOP: begin
            if (tick) begin
               case (m_ff.q)
                  2'h0: nxt_m.oe  = 1'b1;
                  2'h1: nxt_m.scl = 1'b1;
                  2'h2: nxt_m.oe  = 1'b0;
                  default: begin
                     nxt_m.st   = M_IDLE;
                     nxt_m.done = 1'b1;
                  end
               endcase
            end
         end
         default: nxt_m.st = M_IDLE;
      endcase
   end

   // Register the master state
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         m_ff <= M_RST;
      end else if (clk_en) begin
         m_ff <= nxt_m;
      end
   end

   assign link.scl        = m_ff.scl;
   assign link.mst_sda_o  = 1'b0;
   assign link.mst_sda_oe = m_ff.oe;
   assign cmd_ready       = m_ff.ready;
   assign wr_take         = m_ff.take;
   assign rd_data         = m_ff.rdd;
   assign rd_valid        = m_ff.rdv;
   assign done            = m_ff.done;
   assign nack_err        = m_ff.err;

endmodule
`default_nettype wire

// *** test/rtc_link_properties.sv ***
// Drive and timing checks on the two-wire link between both ends
`timescale 1ns/1ps
`default_nettype none
module rtc_link_properties (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Link
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_oe,
   input wire logic mst_sda_oe
);
   // ****
   // Link checks
   // ****
   default clocking lk @(posedge ref_clk); endclocking
   default disable iff (reset);
   // Sampled on the fast clock: the link is far slower, so no edge is lost
   dev_stable_a:
      assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device moved data while clock high");
   no_contention_a:
      assert property (scl |-> !(dev_sda_oe && mst_sda_oe))
      else $error("both ends pull data with clock high");
   start_idle_a:
      assert property ($rose(mst_sda_oe) && scl |-> $past(sda))
      else $error("start on busy line");
   start_by_master_a:
      assert property ($fell(sda) && scl |-> mst_sda_oe)
      else $error("start not made by master");
   clock_high_a:
      assert property ($rose(scl) |-> ##119 scl)
      else $error("clock high too short");
   clock_low_a:
      assert property ($fell(scl) |-> ##259 !scl)
      else $error("clock low too short");
   ack_hold_a:
      assert property ($rose(scl) && dev_sda_oe |-> ##240 (dev_sda_oe && !sda))
      else $error("device low not held over clock high");
   stop_release_a:
      assert property ($rose(sda) && scl |=> (!dev_sda_oe && !mst_sda_oe)[*8])
      else $error("data not released after stop");
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Bench: master and clock chip front end joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rtc_link_pkg::*;
   logic       ref_clk = 1'b0, link_clk = 1'b0, reset = 1'b1;
   logic       supply_fail = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0;
   logic       cmd_set_ptr = 1'b0, halt_seen = 1'b0;
   logic [5:0] cmd_word_addr = 6'h00, cmd_len = 6'h01;
   logic [1:0] widx = 2'h0, ridx = 2'h0;
   logic [7:0] wbuf [4], rbuf [4], rd_data;
   logic       cmd_ready, wr_take, rd_valid, done, nack_err;
   logic       update_halt, write_protect;
   wire  [7:0] wr_data = wbuf[widx];
   int         err_count = 0, tests_run = 0;
   rtc_link_if lnk ();
   // Short recovery so the protected window fits in the run
   rtc_serial_slave_dev #(.REC_CYCLES(30000)) i_rtc_serial_slave_dev (
      .ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
      .link_clk(link_clk), .link(lnk), .supply_fail(supply_fail),
      .update_halt(update_halt), .write_protect(write_protect));
   rtc_bus_master i_rtc_bus_master (
      .ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .link(lnk),
      .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_set_ptr(cmd_set_ptr),
      .cmd_word_addr(cmd_word_addr), .cmd_len(cmd_len),
      .cmd_ready(cmd_ready), .wr_data(wr_data), .wr_take(wr_take),
      .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
      .nack_err(nack_err));
   rtc_link_properties i_rtc_link_properties (
      .ref_clk(ref_clk), .reset(reset), .scl(lnk.scl), .sda(lnk.sda),
      .dev_sda_oe(lnk.dev_sda_oe), .mst_sda_oe(lnk.mst_sda_oe));
   // Clocks, the link clock offset so the two never line up
   initial forever #2.5 ref_clk = ~ref_clk;
   initial begin
      #7.3;
      forever #16 link_clk = ~link_clk;
   end
   // Collect read bytes, step the write queue, note any halt; queues
   // restart when the master takes a command, halt note on supply fail
   always @(posedge ref_clk) begin
      if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
         widx <= 2'h0;
         ridx <= 2'h0;
      end
      if (rd_valid === 1'b1) begin
         rbuf[ridx] <= rd_data;
         ridx <= ridx + 2'h1;
      end
      if (wr_take === 1'b1) widx <= widx + 2'h1;
      if (supply_fail === 1'b1) begin
         halt_seen <= 1'b0;
      end else if (update_halt === 1'b1) begin
         halt_seen <= 1'b1;
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One command, held until taken, then waited on to done
   task automatic xfer(input logic rd, input logic sp, input logic [5:0] a,
                       input logic [5:0] n);
      int k;
      @(posedge ref_clk);
      cmd_read <= rd;
      cmd_set_ptr <= sp;
      cmd_word_addr <= a;
      cmd_len <= n;
      cmd_valid <= 1'b1;
      @(posedge ref_clk);
      for (k = 0; k < 50 && cmd_ready !== 1'b1; k++) @(posedge ref_clk);
      cmd_valid <= 1'b0;
      for (k = 0; k < 40000 && done !== 1'b1; k++) @(posedge ref_clk);
      chk({7'h00, done}, 8'h01);
      chk({7'h00, nack_err}, 8'h00);
   endtask
   task automatic report_and_stop;
      if (err_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Watchdog well past the expected run
   initial begin
      #600000;
      err_count++;
      $display("[ERR] %0t watchdog", $time);
      report_and_stop();
   end
   // ****
   // Scenarios
   // ****
   initial begin
      void'($urandom(36));
      for (int i = 0; i < 3; i++) wbuf[i] = 8'($urandom);
      repeat (40) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (4) @(posedge ref_clk);
      xfer(1'b0, 1'b1, 6'h3E, 6'h03);
      xfer(1'b1, 1'b1, 6'h3D, 6'h02);
      chk(rbuf[0], MEM_RST);
      chk(rbuf[1], wbuf[0]);
      supply_fail <= 1'b1;
      repeat (20) @(posedge ref_clk);
      supply_fail <= 1'b0;
      @(posedge ref_clk);
      chk({7'h00, write_protect}, 8'h01);
      // Pointer must restart at 00h, where the wrapped write landed
      xfer(1'b1, 1'b0, 6'h00, 6'h01);
      chk(rbuf[0], wbuf[2]);
      chk({7'h00, halt_seen}, 8'h01);
      wbuf[3] = wbuf[0];
      wbuf[0] = ~wbuf[0];
      xfer(1'b0, 1'b1, 6'h3E, 6'h01);
      chk({7'h00, update_halt}, 8'h00);
      xfer(1'b1, 1'b1, 6'h3E, 6'h01);
      chk(rbuf[0], wbuf[3]);
      chk({7'h00, write_protect}, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
